// ---- hw/code_classifier.sv ----
// Purpose: Sorts an instruction code word into a class and number
// Assumes: Code word is stable while it is sampled
// Notes: Purely combinational
`timescale 1ns/1ns
`default_nettype none
module code_classifier
    import wcmd_pkg::*;
(
    input wire logic [15:0] code,
    output var op_t op,
    output logic [7:0] num
);
    logic [7:0] hi;
    logic in_write_space;
    logic low_nz;

    // Field split of the code word
    assign hi = code[15:8];
    assign num = code[7:0]; // RULE10
    assign low_nz = (code[7:0] != 8'h00);
    assign in_write_space = (code >= WR_SPACE_LO) && (code <= WR_SPACE_HI); // RULE1

    // Class decode, anything unlisted is a bad code
    always_comb
    begin
        op = OP_BAD;
        if (code == CODE_GROUP_READ)
            op = OP_GRD;
        else if (code == CODE_ALARM_RESET)
            op = OP_ALM;
        else if (code == CODE_FB_CLEAR)
            op = OP_FBC;
        else if (code == CODE_GROUP_WRITE)
            op = OP_GRP;
        else if (in_write_space && low_nz)
        begin
            case (hi)
                HI_PAR_RAM: op = OP_PRAM;
                HI_PAR_NV: op = OP_PNV;
                HI_SPD_RAM: op = OP_SPD_RAM;
                HI_ACC_RAM: op = OP_ACC_RAM;
                HI_DEC_RAM: op = OP_DEC_RAM; // RULE14
                HI_SPD_NV: op = OP_SPD_NV;
                HI_ACC_NV: op = OP_ACC_NV; // RULE16
                HI_DEC_NV: op = OP_DEC_NV; // RULE17
                default: op = OP_BAD;
            endcase
        end
    end
endmodule : code_classifier
`default_nettype wire

// ---- hw/servo_write_command_decoder.sv ----
// Purpose: Executes write instruction codes from the cyclic words
// Assumes: One instruction per instr_valid pulse, all inputs synchronous
// Notes: Response and strobes appear one clock after the request
//
// Function
// RULE1 - Write instruction space spans codes 8010h through 91FFh
// RULE2 - Code, data and response are each one 16-bit word
// RULE3 - Undefined code stores an error response and does nothing
// RULE4 - 8010h with data 1EA5 clears the active alarm
// RULE5 - 8101h with data 1EA5 zeroes the feedback pulse display
// RULE6 - 8200h latches data as the selected parameter group
// RULE7 - Group 0 basic, 1 gain/filter, 2 extension, 3 I/O
// RULE8 - 8201h-82FFh write a parameter to volatile storage
// RULE9 - 8301h-83FFh write a parameter to non-volatile storage
// RULE10 - Low byte of a ranged code is the item number
// RULE11 - Parameter write refused beyond access limit or setting range
// RULE12 - 8601h-86FFh write point speed to volatile storage
// RULE13 - 8701h-87FFh write point acceleration to volatile storage
// RULE14 - 8801h-88FFh write point deceleration to volatile storage
// RULE15 - 8D01h-8DFFh write point speed to non-volatile storage
// RULE16 - 8E01h-8EFFh write point acceleration to non-volatile storage
// RULE17 - 8F01h-8FFFh write point deceleration to non-volatile storage
// RULE18 - Master converts decimal values to hexadecimal before writing
// RULE19 - Response 0000 when everything is valid, else an error code
// RULE20 - Response 1 for a bad code or point entry 255
// RULE21 - Response 2 for a parameter number whose reference is disabled
// RULE22 - Response 3 for write data outside the setting range
// RULE23 - Read code 0200h returns the selected parameter group
// RULE24 - Response updates once per instruction and then holds
`timescale 1ns/1ns
`default_nettype none
module servo_write_command_decoder
    import wcmd_pkg::*;
#(
    parameter logic [15:0] PT_SPEED_MAX = 16'hffff,
    parameter logic [15:0] PT_TIME_MAX = 16'hffff
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic instr_valid,
    input wire logic [15:0] instruction_code_word,
    input wire logic [15:0] write_data_word,
    input wire logic [7:0] parameter_access_limit,
    input wire logic [15:0] param_min,
    input wire logic [15:0] param_max,
    output logic [7:0] query_number,
    output logic [1:0] query_group,
    output logic response_valid,
    output logic [15:0] response_code_word,
    output logic [15:0] read_data_word,
    output logic alarm_reset,
    output logic feedback_clear,
    output logic [1:0] param_group,
    output logic basic_setting_group,
    output logic gain_filter_group,
    output logic extension_setting_group,
    output logic io_setting_group,
    output logic param_write,
    output logic param_write_nv,
    output logic pt_write,
    output logic pt_write_nv,
    output logic [1:0] pt_field,
    output logic [7:0] target_number,
    output logic [15:0] target_data
);
    op_t op;
    logic [7:0] code_num;
    logic [15:0] check_code;
    logic accept_ok;
    logic do_alarm;
    logic do_fb;
    logic do_group;
    logic do_param;
    logic do_pt;
    logic do_read;
    logic [15:0] nxt_resp;
    logic [1:0] nxt_group;
    logic [15:0] nxt_read;
    logic [7:0] nxt_number;
    logic [15:0] nxt_data;
    logic resp_valid_ff;
    logic [15:0] resp_ff;
    logic [15:0] read_ff;
    logic [1:0] group_ff;
    logic alarm_ff;
    logic fb_ff;
    logic par_wr_ff;
    logic par_nv_ff;
    logic pt_wr_ff;
    logic pt_nv_ff;
    logic [1:0] field_ff;
    logic [7:0] number_ff;
    logic [15:0] data_ff;

    // Code word classification
    code_classifier u_class (
        .code(instruction_code_word),
        .op(op),
        .num(code_num)
    );

    // Range and permission checks
    write_limit_check #(
        .PT_SPEED_MAX(PT_SPEED_MAX),
        .PT_TIME_MAX(PT_TIME_MAX)
    ) u_check (
        .op(op),
        .num(code_num),
        .data(write_data_word),
        .access_limit(parameter_access_limit),
        .param_min(param_min),
        .param_max(param_max),
        .resp(check_code)
    );

    // Parameter bound lookup address for the outside table
    assign query_number = code_num;
    assign query_group = group_ff; // RULE6

    // Actions only run when every check passed
    assign accept_ok = instr_valid && (check_code == RESP_OK); // RULE3
    assign do_alarm = accept_ok && (op == OP_ALM); // RULE4
    assign do_fb = accept_ok && (op == OP_FBC); // RULE5
    assign do_group = accept_ok && (op == OP_GRP); // RULE6
    assign do_param = accept_ok && op_is_param(op); // RULE8
    assign do_pt = accept_ok && op_is_point(op); // RULE12
    assign do_read = accept_ok && (op == OP_GRD); // RULE23

    // Next values of the held words
    assign nxt_resp = instr_valid ? check_code : resp_ff; // RULE24
    assign nxt_group = do_group ? write_data_word[1:0] : group_ff; // RULE6
    assign nxt_read = do_read ? {14'h0, group_ff} : read_ff; // RULE23
    assign nxt_number = instr_valid ? code_num : number_ff; // RULE10
    assign nxt_data = instr_valid ? write_data_word : data_ff; // RULE2

    // Response word and strobe
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            resp_ff <= RESP_RESET;
            resp_valid_ff <= 1'b0;
        end
        else
        begin
            resp_ff <= nxt_resp;
            resp_valid_ff <= instr_valid;
        end
    end

    // Group selector and read-back word
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            group_ff <= GROUP_RESET;
            read_ff <= 16'h0000;
        end
        else
        begin
            group_ff <= nxt_group;
            read_ff <= nxt_read;
        end
    end

    // One-clock command strobes
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            alarm_ff <= 1'b0;
            fb_ff <= 1'b0;
            par_wr_ff <= 1'b0;
            par_nv_ff <= 1'b0;
            pt_wr_ff <= 1'b0;
            pt_nv_ff <= 1'b0;
        end
        else
        begin
            alarm_ff <= do_alarm;
            fb_ff <= do_fb;
            par_wr_ff <= do_param;
            par_nv_ff <= do_param && op_is_nv(op); // RULE9
            pt_wr_ff <= do_pt;
            pt_nv_ff <= do_pt && op_is_nv(op); // RULE15
        end
    end

    // Target item and data held for the storage side
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            field_ff <= FIELD_SPEED;
            number_ff <= 8'h00;
            data_ff <= 16'h0000;
        end
        else
        begin
            field_ff <= do_pt ? op_field(op) : field_ff; // RULE13
            number_ff <= nxt_number;
            data_ff <= nxt_data;
        end
    end

    // Output drive
    assign response_valid = resp_valid_ff;
    assign response_code_word = resp_ff;
    assign read_data_word = read_ff;
    assign alarm_reset = alarm_ff;
    assign feedback_clear = fb_ff;
    assign param_group = group_ff;
    assign param_write = par_wr_ff;
    assign param_write_nv = par_nv_ff;
    assign pt_write = pt_wr_ff;
    assign pt_write_nv = pt_nv_ff;
    assign pt_field = field_ff;
    assign target_number = number_ff;
    assign target_data = data_ff;

    // Group selector decode
    assign basic_setting_group = (group_ff == GROUP_BASIC); // RULE7
    assign gain_filter_group = (group_ff == GROUP_GAIN); // RULE7
    assign extension_setting_group = (group_ff == GROUP_EXT); // RULE7
    assign io_setting_group = (group_ff == GROUP_IO); // RULE7

    // Checks on the decoder
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    property p_resp_once;
        instr_valid |=> response_valid;
    endproperty
    a_resp_once: assert property (p_resp_once) // RULE24
        else $error("response strobe missing after a request");

    property p_resp_hold;
        !instr_valid |=> !response_valid && $stable(response_code_word);
    endproperty
    a_resp_hold: assert property (p_resp_hold) // RULE24
        else $error("response changed with no request");

    property p_no_action_on_error;
        response_valid && (response_code_word != RESP_OK)
            |-> !(alarm_reset || feedback_clear || param_write || pt_write);
    endproperty
    a_no_action_on_error: assert property (p_no_action_on_error) // RULE3
        else $error("action taken despite an error response");

    property p_undefined;
        instr_valid && (instruction_code_word == 16'h8000)
            |=> response_code_word == RESP_CODE_ERR;
    endproperty
    a_undefined: assert property (p_undefined) // RULE1
        else $error("code outside the write space not refused");

    property p_alarm;
        instr_valid && (instruction_code_word == CODE_ALARM_RESET)
            && (write_data_word == CLEAR_KEY)
            |=> alarm_reset && (response_code_word == RESP_OK) ##1 !alarm_reset;
    endproperty
    a_alarm: assert property (p_alarm) // RULE4
        else $error("alarm reset not a single pulse");

    property p_fb_clear;
        instr_valid && (instruction_code_word == CODE_FB_CLEAR)
            |=> feedback_clear == ($past(write_data_word) == CLEAR_KEY);
    endproperty
    a_fb_clear: assert property (p_fb_clear) // RULE5
        else $error("feedback clear does not follow its key");

    property p_group;
        instr_valid && (instruction_code_word == CODE_GROUP_WRITE)
            && (write_data_word[15:2] == 14'h0)
            |=> param_group == $past(write_data_word[1:0]);
    endproperty
    a_group: assert property (p_group) // RULE6
        else $error("group selector not latched");

    property p_group_decode;
        $onehot({io_setting_group, extension_setting_group,
            gain_filter_group, basic_setting_group})
            && (gain_filter_group == (param_group == 2'h1));
    endproperty
    a_group_decode: assert property (p_group_decode) // RULE7
        else $error("group decode not one-hot");

    property p_param_ram;
        instr_valid && (instruction_code_word[15:8] == HI_PAR_RAM)
            && (check_code == RESP_OK) && (code_num != 8'h00)
            |=> param_write && !param_write_nv
            && (target_number == $past(instruction_code_word[7:0]));
    endproperty
    a_param_ram: assert property (p_param_ram) // RULE8
        else $error("volatile parameter write missing");

    property p_param_nv;
        param_write_nv |-> param_write && ($past(op) == OP_PNV);
    endproperty
    a_param_nv: assert property (p_param_nv) // RULE9
        else $error("non-volatile write from the wrong code");

    property p_sel_err;
        instr_valid && (instruction_code_word[15:8] == HI_PAR_NV)
            && (code_num > parameter_access_limit)
            |=> (response_code_word == RESP_SEL_ERR) && !param_write;
    endproperty
    a_sel_err: assert property (p_sel_err) // RULE21
        else $error("parameter beyond the access limit accepted");

    property p_pt_last;
        instr_valid && (instruction_code_word == 16'h86ff)
            |=> (response_code_word == RESP_CODE_ERR) && !pt_write;
    endproperty
    a_pt_last: assert property (p_pt_last) // RULE20
        else $error("point entry 255 accepted");

    property p_pt_speed_nv;
        instr_valid && (instruction_code_word == 16'h8d01)
            && (write_data_word <= PT_SPEED_MAX)
            |=> pt_write && pt_write_nv && (pt_field == FIELD_SPEED);
    endproperty
    a_pt_speed_nv: assert property (p_pt_speed_nv) // RULE15
        else $error("point speed store not non-volatile");

    property p_read_group;
        instr_valid && (instruction_code_word == CODE_GROUP_READ)
            |=> read_data_word == {14'h0, $past(param_group)};
    endproperty
    a_read_group: assert property (p_read_group) // RULE23
        else $error("group read-back wrong");

    // Main scenarios
    c_alarm: cover property (alarm_reset);
    c_param_nv: cover property (param_write_nv);
    c_pt_decel: cover property (pt_write && (pt_field == FIELD_DECEL));
    c_range_err: cover property (response_valid && (response_code_word == RESP_RANGE_ERR));
endmodule : servo_write_command_decoder
`default_nettype wire

// ---- hw/wcmd_pkg.sv ----
// Purpose: Shared constants and types for the write instruction decoder
// Assumes: Instruction, data and response words are 16 bits wide
// Notes: Instruction classes are decoded from the code word
package wcmd_pkg;
    localparam int WORD_W = 16;
    localparam logic [15:0] WR_SPACE_LO = 16'h8010;
    localparam logic [15:0] WR_SPACE_HI = 16'h91ff;
    localparam logic [15:0] CODE_ALARM_RESET = 16'h8010;
    localparam logic [15:0] CODE_FB_CLEAR = 16'h8101;
    localparam logic [15:0] CODE_GROUP_WRITE = 16'h8200;
    localparam logic [15:0] CODE_GROUP_READ = 16'h0200;
    localparam logic [7:0] HI_PAR_RAM = 8'h82;
    localparam logic [7:0] HI_PAR_NV = 8'h83;
    localparam logic [7:0] HI_SPD_RAM = 8'h86;
    localparam logic [7:0] HI_ACC_RAM = 8'h87;
    localparam logic [7:0] HI_DEC_RAM = 8'h88;
    localparam logic [7:0] HI_SPD_NV = 8'h8d;
    localparam logic [7:0] HI_ACC_NV = 8'h8e;
    localparam logic [7:0] HI_DEC_NV = 8'h8f;
    localparam logic [15:0] CLEAR_KEY = 16'h1ea5;
    localparam logic [1:0] GROUP_BASIC = 2'h0;
    localparam logic [1:0] GROUP_GAIN = 2'h1;
    localparam logic [1:0] GROUP_EXT = 2'h2;
    localparam logic [1:0] GROUP_IO = 2'h3;
    localparam logic [1:0] GROUP_RESET = 2'h0;
    localparam logic [7:0] PT_LAST_BAD = 8'hff;
    localparam logic [15:0] RESP_OK = 16'h0000;
    localparam logic [15:0] RESP_CODE_ERR = 16'h0001;
    localparam logic [15:0] RESP_SEL_ERR = 16'h0002;
    localparam logic [15:0] RESP_RANGE_ERR = 16'h0003;
    localparam logic [15:0] RESP_RESET = 16'h0000;
    localparam logic [1:0] FIELD_SPEED = 2'h0;
    localparam logic [1:0] FIELD_ACCEL = 2'h1;
    localparam logic [1:0] FIELD_DECEL = 2'h2;

    typedef enum logic [3:0] {
        OP_BAD = 4'h0, OP_ALM = 4'h1, OP_FBC = 4'h2, OP_GRP = 4'h3,
        OP_PRAM = 4'h4, OP_PNV = 4'h5, OP_SPD_RAM = 4'h6, OP_ACC_RAM = 4'h7,
        OP_DEC_RAM = 4'h8, OP_SPD_NV = 4'h9, OP_ACC_NV = 4'ha, OP_DEC_NV = 4'hb,
        OP_GRD = 4'hc
    } op_t;

    // Point table write classes
    function automatic logic op_is_point(input op_t op);
        return op inside {OP_SPD_RAM, OP_ACC_RAM, OP_DEC_RAM, OP_SPD_NV, OP_ACC_NV, OP_DEC_NV};
    endfunction : op_is_point

    // Parameter write classes
    function automatic logic op_is_param(input op_t op);
        return op inside {OP_PRAM, OP_PNV};
    endfunction : op_is_param

    // Classes that target non-volatile storage
    function automatic logic op_is_nv(input op_t op);
        return op inside {OP_PNV, OP_SPD_NV, OP_ACC_NV, OP_DEC_NV};
    endfunction : op_is_nv

    // Point table field addressed by a class
    function automatic logic [1:0] op_field(input op_t op);
        if (op inside {OP_ACC_RAM, OP_ACC_NV})
            return FIELD_ACCEL;
        if (op inside {OP_DEC_RAM, OP_DEC_NV})
            return FIELD_DECEL;
        return FIELD_SPEED;
    endfunction : op_field
endpackage : wcmd_pkg

// ---- hw/write_limit_check.sv ----
// Purpose: Works out the response code for one instruction
// Assumes: Parameter bounds arrive for the queried number
// Notes: Purely combinational
`timescale 1ns/1ns
`default_nettype none
module write_limit_check
    import wcmd_pkg::*;
#(
    parameter logic [15:0] PT_SPEED_MAX = 16'hffff,
    parameter logic [15:0] PT_TIME_MAX = 16'hffff
)
(
    input wire op_t op,
    input wire logic [7:0] num,
    input wire logic [15:0] data,
    input wire logic [7:0] access_limit,
    input wire logic [15:0] param_min,
    input wire logic [15:0] param_max,
    output var logic [15:0] resp
);
    logic [15:0] pt_max;
    logic par_num_bad;
    logic par_data_bad;

    // Limits of the addressed item
    assign pt_max = (op_field(op) == FIELD_SPEED) ? PT_SPEED_MAX : PT_TIME_MAX;
    assign par_num_bad = (num > access_limit); // RULE11
    assign par_data_bad = (data < param_min) || (data > param_max); // RULE11

    // First failing check sets the code
    always_comb
    begin
        resp = RESP_OK; // RULE19
        if (op == OP_BAD)
            resp = RESP_CODE_ERR; // RULE3
        else if (op_is_point(op))
        begin
            if (num == PT_LAST_BAD)
                resp = RESP_CODE_ERR; // RULE20
            else if (data > pt_max)
                resp = RESP_RANGE_ERR; // RULE22
        end
        else if (op_is_param(op))
        begin
            if (par_num_bad)
                resp = RESP_SEL_ERR; // RULE21
            else if (par_data_bad)
                resp = RESP_RANGE_ERR; // RULE22
        end
        else if ((op == OP_ALM) || (op == OP_FBC))
        begin
            if (data != CLEAR_KEY)
                resp = RESP_RANGE_ERR;
        end
        else if (op == OP_GRP)
        begin
            if (data > {14'h0, GROUP_IO})
                resp = RESP_RANGE_ERR;
        end
    end
endmodule : write_limit_check
`default_nettype wire

// ---- tb/param_range_model.sv ----
// Purpose: Setting-range table standing behind the decoder for parameter writes
// Assumes: Bounds depend only on the queried group and number
// Notes: Combinational, answers in the cycle of the query
`timescale 1ns/1ns
`default_nettype none
module param_range_model
(
    input wire logic [1:0] query_group,
    input wire logic [7:0] query_number,
    output logic [15:0] param_min,
    output logic [15:0] param_max
);
    // Floor is fixed, ceiling moves with group and number so a wrong group shows
    assign param_min = 16'h0002;
    assign param_max = {6'h01, query_group, query_number};
endmodule : param_range_model
`default_nettype wire

// ---- tb/servo_write_command_decoder_tb_top.sv ----
// Purpose: Self-checking bench for the write instruction decoder
// Assumes: Inputs change on the falling edge, answers land one clock later
// Notes: Point data limits shrunk so range refusals are reachable
`timescale 1ns/1ns
`default_nettype none
module servo_write_command_decoder_tb_top
    import wcmd_pkg::*;
;
    logic clock, rst, instr_valid;
    logic [15:0] instruction_code_word, write_data_word;
    wire logic [15:0] param_min, param_max, response_code_word, read_data_word, target_data;
    wire logic [7:0] query_number, target_number;
    wire logic [1:0] query_group, param_group, pt_field;
    wire logic response_valid, alarm_reset, feedback_clear, param_write, param_write_nv, pt_write, pt_write_nv;
    wire logic basic_setting_group, gain_filter_group, extension_setting_group, io_setting_group;
    wire logic [5:0] strobes;
    int fails = 0;
    int cmp_count = 0;
    localparam logic [15:0] SPD_MAX = 16'h1000;
    localparam logic [15:0] TIME_MAX = 16'h2000;
    logic [7:0] access_limit;

    // All action strobes side by side
    assign strobes = {alarm_reset, feedback_clear, param_write, param_write_nv, pt_write, pt_write_nv};

    servo_write_command_decoder #(.PT_SPEED_MAX(SPD_MAX), .PT_TIME_MAX(TIME_MAX)) DUT (
        .clock(clock), .rst(rst), .instr_valid(instr_valid),
        .instruction_code_word(instruction_code_word), .write_data_word(write_data_word),
        .parameter_access_limit(access_limit), .param_min(param_min), .param_max(param_max),
        .query_number(query_number), .query_group(query_group), .response_valid(response_valid),
        .response_code_word(response_code_word), .read_data_word(read_data_word),
        .alarm_reset(alarm_reset), .feedback_clear(feedback_clear), .param_group(param_group),
        .basic_setting_group(basic_setting_group), .gain_filter_group(gain_filter_group),
        .extension_setting_group(extension_setting_group), .io_setting_group(io_setting_group),
        .param_write(param_write), .param_write_nv(param_write_nv), .pt_write(pt_write),
        .pt_write_nv(pt_write_nv), .pt_field(pt_field), .target_number(target_number),
        .target_data(target_data));

    param_range_model u_range (.query_group(query_group), .query_number(query_number),
        .param_min(param_min), .param_max(param_max));

    // Clock source
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic test_done();
        if (fails == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done

    // One request, judged in the answer cycle
    task automatic req(input logic [15:0] code, input logic [15:0] data, input logic [15:0] resp,
                       input logic [5:0] stb);
        @(negedge clock);
        instr_valid = 1'b1;
        instruction_code_word = code;
        write_data_word = data;
        @(negedge clock);
        instr_valid = 1'b0;
        chk("response_valid", {15'h0, response_valid}, 16'h0001);
        chk("response_code_word", response_code_word, resp);
        chk("strobes", {10'h0, strobes}, {10'h0, stb});
        chk("target_number", {8'h0, target_number}, {8'h0, code[7:0]});
    endtask : req

    task automatic t_reset();
        chk("reset response", response_code_word, 16'h0000);
        chk("reset group", {14'h0, param_group}, 16'h0000);
        chk("reset basic", {15'h0, basic_setting_group}, 16'h0001);
        chk("reset strobes", {9'h0, response_valid, strobes}, 16'h0000);
    endtask : t_reset

    task automatic t_clear_cmds();
        req(16'h8010, 16'h1ea5, RESP_OK, 6'h20);
        chk("target_data", target_data, 16'h1ea5);
        req(16'h8010, 16'h1ea4, RESP_RANGE_ERR, 6'h00);
        req(16'h8101, 16'h1ea5, RESP_OK, 6'h10);
        req(16'h8101, 16'h0000, RESP_RANGE_ERR, 6'h00);
    endtask : t_clear_cmds

    task automatic t_groups();
        for (int g = 0; g < 4; g++)
        begin
            req(16'h8200, 16'(g), RESP_OK, 6'h00);
            chk("param_group", {14'h0, param_group}, 16'(g));
            chk("group decode", {12'h0, io_setting_group, extension_setting_group, gain_filter_group,
                basic_setting_group}, 16'(1 << g));
            req(16'h0200, 16'h0000, RESP_OK, 6'h00);
            chk("read_data_word", read_data_word, 16'(g));
        end
        req(16'h8200, 16'h0004, RESP_RANGE_ERR, 6'h00);
        chk("group kept", {14'h0, param_group}, 16'h0003);
    endtask : t_groups

    task automatic t_params();
        // 0500h fits the group 2 ceiling of 0605h but not the group 0 one of 0405h
        req(16'h8200, 16'h0002, RESP_OK, 6'h00);
        req(16'h8205, 16'h0500, RESP_OK, 6'h08);
        req(16'h8305, 16'h0500, RESP_OK, 6'h0c);
        req(16'h8200, 16'h0000, RESP_OK, 6'h00);
        req(16'h8205, 16'h0500, RESP_RANGE_ERR, 6'h00);
        req(16'h8205, 16'h0064, RESP_OK, 6'h08);
        req(16'h8305, 16'h0001, RESP_RANGE_ERR, 6'h00);
        req(16'h8220, 16'h0064, RESP_OK, 6'h08);
        req(16'h8221, 16'h0064, RESP_SEL_ERR, 6'h00);
        req(16'h8321, 16'h9999, RESP_SEL_ERR, 6'h00);
        // Raised limit now admits the same number
        access_limit = 8'h21;
        req(16'h8321, 16'h0064, RESP_OK, 6'h0c);
    endtask : t_params

    task automatic t_points();
        logic [7:0] hi [6] = '{HI_SPD_RAM, HI_ACC_RAM, HI_DEC_RAM, HI_SPD_NV, HI_ACC_NV, HI_DEC_NV};
        logic [15:0] lim;
        for (int i = 0; i < 6; i++)
        begin
            lim = (i % 3 == 0) ? SPD_MAX : TIME_MAX;
            req({hi[i], 8'h01}, lim, RESP_OK, {4'h0, 1'b1, i > 2});
            chk("pt_field", {14'h0, pt_field}, 16'(i % 3));
            chk("target_data", target_data, lim);
            req({hi[i], 8'hfe}, 16'h0000, RESP_OK, {4'h0, 1'b1, i > 2});
            req({hi[i], 8'h02}, lim + 16'h0001, RESP_RANGE_ERR, 6'h00);
            req({hi[i], 8'hff}, 16'h0000, RESP_CODE_ERR, 6'h00);
            req({hi[i], 8'h00}, 16'h0000, RESP_CODE_ERR, 6'h00);
        end
    endtask : t_points

    task automatic t_undefined();
        logic [15:0] bad [7] = '{16'h8000, 16'h8400, 16'h91ff, 16'h800f, 16'h8011, 16'h0100, 16'h8c01};
        foreach (bad[i])
            req(bad[i], 16'h1ea5, RESP_CODE_ERR, 6'h00);
    endtask : t_undefined

    task automatic t_back_to_back();
        @(negedge clock);
        instr_valid = 1'b1;
        instruction_code_word = 16'h8010;
        write_data_word = 16'h1ea5;
        @(negedge clock);
        instruction_code_word = 16'h8400;
        chk("first valid", {15'h0, response_valid}, 16'h0001);
        chk("first strobes", {10'h0, strobes}, 16'h0020);
        @(negedge clock);
        instr_valid = 1'b0;
        chk("second valid", {15'h0, response_valid}, 16'h0001);
        chk("second response", response_code_word, RESP_CODE_ERR);
        chk("second strobes", {10'h0, strobes}, 16'h0000);
        repeat (3) @(negedge clock);
        chk("idle valid", {15'h0, response_valid}, 16'h0000);
        chk("held response", response_code_word, RESP_CODE_ERR);
    endtask : t_back_to_back

    // Main sequence
    initial
    begin
        rst = 1'b1;
        access_limit = 8'h20;
        instr_valid = 1'b0;
        instruction_code_word = 16'h0000;
        write_data_word = 16'h0000;
        repeat (20) @(negedge clock);
        rst = 1'b0;
        t_reset();
        t_clear_cmds();
        t_groups();
        t_params();
        t_points();
        t_undefined();
        t_back_to_back();
        test_done();
    end

    // Watchdog, far beyond the roughly 150 cycles the tests need
    initial
    begin
        #(100 * 5000);
        fails++;
        test_done();
    end
endmodule : servo_write_command_decoder_tb_top
`default_nettype wire
